// *** status_event_pkg.sv ***
package status_event_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] PRIMARY_OFS    = 12'h110;
  localparam logic [11:0] SECONDARY_OFS  = 12'h114;
  localparam logic [11:0] INT_STATUS_OFS = 12'h118;
  localparam logic [11:0] INT_ENABLE_OFS = 12'h11c;
  localparam logic [11:0] EDGE_CFG_OFS   = 12'h120;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [21:0] INT_ENABLE_RST   = 22'h000000;
  localparam logic [11:0] EDGE_CFG_RST     = 12'h000;
  localparam logic        XFER_TIMEOUT_RST = 1'b1;

  // ****************************************
  // Bit positions used as clear keys, plus the pin field base and the event width
  // ****************************************
  localparam int P_XFER_EVENT  = 18;
  localparam int P_TW_ERROR    = 16;
  localparam int P_AUDIO_FIFO  = 11;
  localparam int P_VIDEO_PROT  = 10;
  localparam int P_VIDEO_FIFO  = 9;
  localparam int P_PIN_LOW     = 3;
  localparam int P_TASK1_ERROR = 24;
  localparam int P_EVENT_BITS  = 22;

  // Edge select field: bit 0 rising, bit 1 falling
  localparam int EDGE_RISE = 0;
  localparam int EDGE_FALL = 1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic       task0_timeout;
    logic       task0_start;
    logic       seq_uploading;
    logic       xfer_unit_busy;
    logic       xfer_cmd_start;
    logic       xfer_timeout_hit;
    logic       xfer_format_hit;
    logic       twowire_busy;
    logic       twowire_start;
    logic [4:0] twowire_err_hit;
    logic [3:0] audio_protect_hit;
    logic [3:0] audio_restart;
    logic [3:0] audio_fifo_hit;
    logic [2:0] video_protect_hit;
    logic [2:0] video_fifo_hit;
    logic [2:0] video_reload;
    logic [5:0] counter_over;
    logic       bus_req;
    logic       bus_gnt;
    logic       bus_master;
    logic       task1_start;
    logic       task1_reg_err_hit;
    logic       task1_page_err_hit;
    logic       task1_running;
  } status_src_t;

endpackage

// *** status_event_collector.sv ***
// Operation
// - Task zero wait timeout sets bit 21
// - Bit 20 shows upload; falling edge latches
// - Bit 19 shows transfer busy; falling latches
// - Bit 18 set by transfer errors
// - Transfer timeout flag resets to one
// - Bit 17 shows two-wire busy; falling latches
// - Bit 16 set by two-wire errors
// - Bits 15..12 audio protection, cleared by restart
// - Bit 11 flags any audio FIFO fault
// - Bit 10 flags video DMA protection errors
// - Bit 9 flags video FIFO faults
// - Bits 8,7 field identity, selected edges latch
// - Bits 6..3 mirror pins, selected edges latch
// - Bit 2 summarises four counter flags
// - Bits 1,0 counters three and zero
// - Secondary 31 request pending until grant
// - Secondary 30 bus master active
// - Secondary 29 task one register error
// - Secondary 28 task one page error
// - Secondary 27 task one running
// - Enabled conditions latch, write one clears
// - Status read-only; write one to primary triggers
module status_event_collector
  import status_event_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire reg_req_t    req,
  output logic [31:0]      reg_rdata,
  input  wire status_src_t src,
  input  wire logic        field_id_a_pin,
  input  wire logic        field_id_b_pin,
  input  wire logic [3:0]  gp_pin,
  output logic             irq
);

  // ****************************************
  // State
  // ****************************************
  logic [5:0]  pin_meta_q;
  logic [5:0]  pin_sync_q;
  logic        to0_q;
  logic        xfer_to_q;
  logic        xfer_ef_q;
  logic        xfer_evt_q;
  logic [4:0]  tw_err_q;
  logic        tw_evt_q;
  logic [3:0]  aprot_q;
  logic [3:0]  afifo_q;
  logic [2:0]  vprot_q;
  logic [2:0]  vfifo_q;
  logic [1:0]  t1err_q;
  logic        req_pend_q;
  logic        master_q;
  logic        t1run_q;
  logic [21:0] prev_q;
  logic [21:0] isr_q;
  logic [21:0] isr_d;
  logic [21:0] int_en_q;
  logic [11:0] edge_cfg_q;
  logic [31:0] rdata_q;

  logic [31:0] primary;
  logic [31:0] secondary;
  logic [31:0] isr_clr;
  logic [21:0] trig;
  logic [21:0] rise;
  logic [21:0] fall;
  logic [5:0]  pin_ev;
  logic [21:0] ev;

  // Decode shared by every write and read path
  function automatic logic hit(input reg_req_t r, input logic [11:0] ofs);
    return r.addr == ofs;
  endfunction

  assign isr_clr = (req.wr && hit(req, INT_STATUS_OFS)) ? req.wdata : 32'h0;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pins are asynchronous; only the second stage feeds logic
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end else if (clk_en) begin
      pin_meta_q <= {field_id_a_pin, field_id_b_pin, gp_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************
  // Sequencer task flags
  // ****************************************
  // Timeout wins over a start in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      to0_q <= 1'b0;
    end else if (clk_en) begin
      if (src.task0_timeout) begin
        to0_q <= 1'b1;
      end else if (src.task0_start) begin
        to0_q <= 1'b0;
      end
    end
  end

  // Task one errors clear on latch write or restart; set wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      t1err_q <= 2'b00;
      t1run_q <= 1'b0;
    end else if (clk_en) begin
      t1err_q <= (t1err_q & ~{2{isr_clr[P_TASK1_ERROR] | src.task1_start}})
               | {src.task1_reg_err_hit, src.task1_page_err_hit};
      t1run_q <= src.task1_running;
    end
  end

  // ****************************************
  // Transfer unit flags
  // ****************************************
  // Timeout flag leaves reset high, so software sees a stale event
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xfer_to_q  <= XFER_TIMEOUT_RST;
      xfer_ef_q  <= 1'b0;
      xfer_evt_q <= 1'b0;
    end else if (clk_en) begin
      if (src.xfer_timeout_hit) begin
        xfer_to_q <= 1'b1;
      end else if (isr_clr[P_XFER_EVENT]) begin
        xfer_to_q <= 1'b0;
      end
      if (src.xfer_format_hit) begin
        xfer_ef_q <= 1'b1;
      end else if (isr_clr[P_XFER_EVENT]) begin
        xfer_ef_q <= 1'b0;
      end
      if (src.xfer_timeout_hit || src.xfer_format_hit) begin
        xfer_evt_q <= 1'b1;
      end else if (src.xfer_cmd_start) begin
        xfer_evt_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Two-wire bus flags
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tw_err_q <= 5'h00;
      tw_evt_q <= 1'b0;
    end else if (clk_en) begin
      tw_err_q <= (tw_err_q & ~{5{isr_clr[P_TW_ERROR] | src.twowire_start}})
                | src.twowire_err_hit;
      if (|src.twowire_err_hit) begin
        tw_evt_q <= 1'b1;
      end else if (src.twowire_start) begin
        tw_evt_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Audio and video DMA flags
  // ****************************************
  // Per-source flags, so one restart does not hide another fault
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aprot_q <= 4'h0;
      afifo_q <= 4'h0;
      vprot_q <= 3'h0;
      vfifo_q <= 3'h0;
    end else if (clk_en) begin
      aprot_q <= (aprot_q & ~src.audio_restart) | src.audio_protect_hit;
      afifo_q <= (afifo_q & ~({4{isr_clr[P_AUDIO_FIFO]}} | src.audio_restart))
               | src.audio_fifo_hit;
      vprot_q <= (vprot_q & ~({3{isr_clr[P_VIDEO_PROT]}} | src.video_reload))
               | src.video_protect_hit;
      vfifo_q <= (vfifo_q & ~({3{isr_clr[P_VIDEO_FIFO]}} | src.video_reload))
               | src.video_fifo_hit;
    end
  end

  // ****************************************
  // PCI master state
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_pend_q <= 1'b0;
      master_q   <= 1'b0;
    end else if (clk_en) begin
      req_pend_q <= src.bus_req & ~src.bus_gnt;
      master_q   <= src.bus_master;
    end
  end

  // ****************************************
  // Status words
  // ****************************************
  // Busy and upload are live levels from same-clock units
  assign primary = {10'h000,
                    to0_q,
                    src.seq_uploading,
                    src.xfer_unit_busy,
                    xfer_evt_q,
                    src.twowire_busy,
                    tw_evt_q,
                    aprot_q,
                    |afifo_q,
                    |vprot_q,
                    |vfifo_q,
                    pin_sync_q,
                    |{src.counter_over[5:4], src.counter_over[2:1]},
                    src.counter_over[3],
                    src.counter_over[0]};

  assign secondary = {req_pend_q, master_q, t1err_q, t1run_q, 3'h0,
                      xfer_to_q, xfer_ef_q, tw_err_q,
                      vprot_q, vfifo_q, afifo_q, 7'h00};

  // ****************************************
  // Interrupt events
  // ****************************************
  assign rise = primary[21:0] & ~prev_q;
  assign fall = ~primary[21:0] & prev_q;

  // Each pin bit picks its own edges from two config bits
  generate
    for (genvar i = 0; i < 6; i++) begin : g_pin_edge
      assign pin_ev[i] = (rise[P_PIN_LOW+i] & edge_cfg_q[2*i+EDGE_RISE])
                       | (fall[P_PIN_LOW+i] & edge_cfg_q[2*i+EDGE_FALL]);
    end
  endgenerate

  // Done-type bits latch on the falling edge, pin bits on their selected edges, the rest on rising
  assign ev = {rise[21], fall[20], fall[19], rise[18], fall[17],
               rise[16:9], pin_ev, rise[2:0]};

  // Software write of one to the primary word fakes the event
  assign trig = (req.wr && hit(req, PRIMARY_OFS)) ? req.wdata[21:0] : 22'h0;

  // Set wins over a clear in the same cycle
  assign isr_d = (isr_q & ~isr_clr[21:0]) | ((ev | trig) & int_en_q);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 22'h000000;
      isr_q  <= 22'h000000;
    end else if (clk_en) begin
      prev_q <= primary[21:0];
      isr_q  <= isr_d;
    end
  end

  assign irq = |isr_q;

  // ****************************************
  // Register port
  // ****************************************
  // Status words have no storage, so primary writes only trigger and secondary writes do nothing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_en_q   <= INT_ENABLE_RST;
      edge_cfg_q <= EDGE_CFG_RST;
    end else if (clk_en && req.wr) begin
      if (hit(req, INT_ENABLE_OFS)) begin
        int_en_q <= req.wdata[21:0];
      end
      if (hit(req, EDGE_CFG_OFS)) begin
        edge_cfg_q <= req.wdata[11:0];
      end
    end
  end

  // Read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else if (clk_en) begin
      if (!req.rd) begin
        rdata_q <= 32'h0;
      end else if (hit(req, PRIMARY_OFS)) begin
        rdata_q <= primary;
      end else if (hit(req, SECONDARY_OFS)) begin
        rdata_q <= secondary;
      end else if (hit(req, INT_STATUS_OFS)) begin
        rdata_q <= {10'h000, isr_q};
      end else if (hit(req, INT_ENABLE_OFS)) begin
        rdata_q <= {10'h000, int_en_q};
      end else if (hit(req, EDGE_CFG_OFS)) begin
        rdata_q <= {20'h00000, edge_cfg_q};
      end else begin
        rdata_q <= 32'h0;
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_sw_trig0;
    req.wr && hit(req, PRIMARY_OFS) && req.wdata[0] && int_en_q[0];
  endsequence

  sequence s_isr0_set;
    isr_q[0] && irq;
  endsequence

  property p_to0_set;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      src.task0_timeout |=> primary[21];
  endproperty
  a_to0_set: assert property (p_to0_set) else $error("timeout bit not set");

  property p_to0_clear;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      $fell(to0_q) |-> $past(src.task0_start);
  endproperty
  a_to0_clear: assert property (p_to0_clear) else $error("timeout cleared early");

  property p_upload_done;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      (prev_q[20] && !src.seq_uploading && int_en_q[20]) |=> isr_q[20];
  endproperty
  a_upload_done: assert property (p_upload_done) else $error("upload end missed");

  property p_xfer_event;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      src.xfer_format_hit |=> primary[18] && secondary[22];
  endproperty
  a_xfer_event: assert property (p_xfer_event) else $error("transfer event missed");

  property p_tw_event;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      src.twowire_err_hit[0] |=> primary[16] && secondary[17];
  endproperty
  a_tw_event: assert property (p_tw_event) else $error("two-wire event missed");

  property p_audio_restart;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      (src.audio_restart[0] && !src.audio_protect_hit[0]) |=> !primary[12];
  endproperty
  a_audio_restart: assert property (p_audio_restart) else $error("restart no clear");

  property p_pin_edge;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      ($rose(pin_sync_q[0]) && edge_cfg_q[EDGE_RISE] && int_en_q[3]) |=> isr_q[3];
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("pin edge missed");

  property p_req_pending;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      (src.bus_req && !src.bus_gnt) |=> secondary[31];
  endproperty
  a_req_pending: assert property (p_req_pending) else $error("request not shown");

  property p_t1_clear;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      (isr_clr[P_TASK1_ERROR] && !src.task1_reg_err_hit) |=> !secondary[29];
  endproperty
  a_t1_clear: assert property (p_t1_clear) else $error("task one error stuck");

  property p_sw_trigger;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      s_sw_trig0 |=> s_isr0_set;
  endproperty
  a_sw_trigger: assert property (p_sw_trigger) else $error("write trigger failed");

  property p_masked;
    @(posedge ref_clk) disable iff (!resetn || !clk_en)
      (!int_en_q[1] && !isr_q[1]) |=> !isr_q[1];
  endproperty
  a_masked: assert property (p_masked) else $error("disabled bit latched");

endmodule

// *** status_event_collector_tb_top.sv ***
module status_event_collector_tb_top;
  import status_event_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        resetn;
  logic        clk_en;
  reg_req_t    req;
  logic [31:0] reg_rdata;
  status_src_t src;
  logic        field_id_a_pin;
  logic        field_id_b_pin;
  logic [3:0]  gp_pin;
  logic        irq;
  int          fail_count;
  int          samples_checked;

  status_event_collector status_event_collector_inst (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .req(req),
    .reg_rdata(reg_rdata), .src(src), .field_id_a_pin(field_id_a_pin),
    .field_id_b_pin(field_id_b_pin), .gp_pin(gp_pin), .irq(irq));

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  always #5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("Checks made %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bus master: strobe for one cycle, data stand the cycle after
  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // Masked compare keeps other scenarios' flags out of the way
  task automatic expect_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    samples_checked++;
    if ((reg_rdata & m) !== e) begin
      fail_count++;
      $display("ERROR %0t register %h read %h expected %h", $time, a, reg_rdata & m, e);
    end
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    samples_checked++;
    if (irq !== e) begin
      fail_count++;
      $display("ERROR %0t interrupt line %b expected %b", $time, irq, e);
    end
  endtask

  // One source field by number; levels and pulses share it
  task automatic set_src(input int k, input int i, input logic v);
    case (k)
      0: src.task0_timeout <= v;
      1: src.task0_start <= v;
      2: src.xfer_cmd_start <= v;
      3: src.xfer_format_hit <= v;
      4: src.xfer_timeout_hit <= v;
      5: src.twowire_start <= v;
      6: src.twowire_err_hit[i] <= v;
      7: src.audio_protect_hit[i] <= v;
      8: src.audio_restart[i] <= v;
      9: src.audio_fifo_hit[i] <= v;
      10: src.video_protect_hit[i] <= v;
      11: src.video_fifo_hit[i] <= v;
      12: src.task1_start <= v;
      13: src.task1_reg_err_hit <= v;
      14: src.task1_page_err_hit <= v;
      15: src.seq_uploading <= v;
      16: src.xfer_unit_busy <= v;
      17: src.twowire_busy <= v;
      18: src.bus_req <= v;
      19: src.bus_gnt <= v;
      20: src.bus_master <= v;
      21: src.task1_running <= v;
      default: src.counter_over[i] <= v;
    endcase
  endtask

  task automatic pulse(input int k, input int i);
    @(posedge ref_clk);
    set_src(k, i, 1'b1);
    @(posedge ref_clk);
    set_src(k, i, 1'b0);
  endtask

  task automatic level(input int k, input int i, input logic v);
    @(posedge ref_clk);
    set_src(k, i, v);
    repeat (2) @(posedge ref_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    expect_reg(PRIMARY_OFS, 32'h003f_ffff, 32'h0);
    expect_reg(SECONDARY_OFS, 32'hffff_ff80, 32'h0080_0000);
    expect_reg(INT_STATUS_OFS, 32'hffff_ffff, 32'h0);
    chk_irq(1'b0);
  endtask

  task automatic t_task0_timeout();
    pulse(0, 0);
    expect_reg(PRIMARY_OFS, 32'h0020_0000, 32'h0020_0000);
    pulse(1, 0);
    expect_reg(PRIMARY_OFS, 32'h0020_0000, 32'h0);
  endtask

  // Latch must come from the falling edge only
  task automatic t_busy_edges();
    int ks[3] = '{15, 16, 17};
    int bs[3] = '{20, 19, 17};
    for (int n = 0; n < 3; n++) begin
      reg_write(INT_ENABLE_OFS, 32'h1 << bs[n]);
      level(ks[n], 0, 1'b1);
      expect_reg(PRIMARY_OFS, 32'h1 << bs[n], 32'h1 << bs[n]);
      expect_reg(INT_STATUS_OFS, 32'h1 << bs[n], 32'h0);
      level(ks[n], 0, 1'b0);
      expect_reg(INT_STATUS_OFS, 32'h003f_ffff, 32'h1 << bs[n]);
      chk_irq(1'b1);
      reg_write(INT_STATUS_OFS, 32'h1 << bs[n]);
      chk_irq(1'b0);
      reg_write(INT_ENABLE_OFS, 32'h0);
    end
  endtask

  task automatic t_xfer_errors();
    reg_write(INT_STATUS_OFS, 32'h1 << P_XFER_EVENT);
    expect_reg(SECONDARY_OFS, 32'h00c0_0000, 32'h0);
    pulse(3, 0);
    expect_reg(SECONDARY_OFS, 32'h00c0_0000, 32'h0040_0000);
    expect_reg(PRIMARY_OFS, 32'h0004_0000, 32'h0004_0000);
    pulse(2, 0);
    expect_reg(PRIMARY_OFS, 32'h0004_0000, 32'h0);
    pulse(4, 0);
    expect_reg(PRIMARY_OFS, 32'h0004_0000, 32'h0004_0000);
    expect_reg(SECONDARY_OFS, 32'h00c0_0000, 32'h00c0_0000);
    reg_write(INT_STATUS_OFS, 32'h1 << P_XFER_EVENT);
    pulse(2, 0);
  endtask

  task automatic t_twowire_errors();
    for (int i = 0; i < 5; i++) begin
      pulse(6, i);
      expect_reg(SECONDARY_OFS, 32'h003e_0000, 32'h1 << (17 + i));
      expect_reg(PRIMARY_OFS, 32'h0001_0000, 32'h0001_0000);
      reg_write(INT_STATUS_OFS, 32'h1 << P_TW_ERROR);
      pulse(5, 0);
      expect_reg(PRIMARY_OFS, 32'h0001_0000, 32'h0);
    end
  endtask

  task automatic t_audio_protect();
    for (int i = 0; i < 4; i++) begin
      pulse(7, i);
      expect_reg(PRIMARY_OFS, 32'h0000_f000, 32'h1 << (12 + i));
      pulse(8, i);
      expect_reg(PRIMARY_OFS, 32'h0000_f000, 32'h0);
    end
  endtask

  // FIFO and protection faults: summary bit, detail bit, clear key
  task automatic t_faults();
    int ks[3] = '{9, 10, 11};
    int ns[3] = '{4, 3, 3};
    int ss[3] = '{7, 14, 11};
    int ps[3] = '{P_AUDIO_FIFO, P_VIDEO_PROT, P_VIDEO_FIFO};
    for (int n = 0; n < 3; n++) begin
      for (int i = 0; i < ns[n]; i++) begin
        pulse(ks[n], i);
        expect_reg(SECONDARY_OFS, 32'h0001_ff80, 32'h1 << (ss[n] + i));
        expect_reg(PRIMARY_OFS, 32'h0000_0e00, 32'h1 << ps[n]);
        reg_write(INT_STATUS_OFS, 32'h1 << ps[n]);
        expect_reg(PRIMARY_OFS, 32'h0000_0e00, 32'h0);
      end
    end
  endtask

  // Rising edges only selected: a falling edge must not latch
  task automatic t_pins();
    reg_write(EDGE_CFG_OFS, 32'h0000_0555);
    reg_write(INT_ENABLE_OFS, 32'h0000_01f8);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      if (i < 4) gp_pin[i] <= 1'b1;
      else if (i == 4) field_id_b_pin <= 1'b1;
      else field_id_a_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      expect_reg(PRIMARY_OFS, 32'h0000_01f8, 32'h1 << (3 + i));
      expect_reg(INT_STATUS_OFS, 32'h0000_01f8, 32'h1 << (3 + i));
      reg_write(INT_STATUS_OFS, 32'h0000_01f8);
      @(posedge ref_clk);
      gp_pin         <= 4'h0;
      field_id_a_pin <= 1'b0;
      field_id_b_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      expect_reg(PRIMARY_OFS, 32'h0000_01f8, 32'h0);
      expect_reg(INT_STATUS_OFS, 32'h0000_01f8, 32'h0);
    end
    // Falling edges only: the rise must not latch, the fall must
    reg_write(EDGE_CFG_OFS, 32'h0000_0aaa);
    @(posedge ref_clk);
    gp_pin <= 4'h1;
    repeat (4) @(posedge ref_clk);
    expect_reg(INT_STATUS_OFS, 32'h0000_01f8, 32'h0);
    @(posedge ref_clk);
    gp_pin <= 4'h0;
    repeat (4) @(posedge ref_clk);
    expect_reg(INT_STATUS_OFS, 32'h0000_01f8, 32'h0000_0008);
    reg_write(INT_STATUS_OFS, 32'h0000_01f8);
    reg_write(INT_ENABLE_OFS, 32'h0);
  endtask

  task automatic t_counters();
    for (int i = 0; i < 6; i++) begin
      level(22, i, 1'b1);
      expect_reg(PRIMARY_OFS, 32'h7, (i == 0) ? 32'h1 : (i == 3) ? 32'h2 : 32'h4);
      level(22, i, 1'b0);
    end
  endtask

  task automatic t_bus_and_task1();
    level(18, 0, 1'b1);
    expect_reg(SECONDARY_OFS, 32'hc800_0000, 32'h8000_0000);
    level(19, 0, 1'b1);
    level(20, 0, 1'b1);
    expect_reg(SECONDARY_OFS, 32'hc800_0000, 32'h4000_0000);
    level(21, 0, 1'b1);
    expect_reg(SECONDARY_OFS, 32'h0800_0000, 32'h0800_0000);
    for (int k = 18; k < 22; k++) level(k, 0, 1'b0);
    pulse(13, 0);
    expect_reg(SECONDARY_OFS, 32'h3000_0000, 32'h2000_0000);
    reg_write(INT_STATUS_OFS, 32'h1 << P_TASK1_ERROR);
    expect_reg(SECONDARY_OFS, 32'h3000_0000, 32'h0);
    pulse(14, 0);
    expect_reg(SECONDARY_OFS, 32'h3800_0000, 32'h1000_0000);
    pulse(12, 0);
    expect_reg(SECONDARY_OFS, 32'h3000_0000, 32'h0);
  endtask

  // Status words are read-only; a written one raises only enabled bits
  task automatic t_soft_trigger();
    reg_write(INT_ENABLE_OFS, 32'h1);
    reg_write(PRIMARY_OFS, 32'h0);
    expect_reg(INT_STATUS_OFS, 32'hffff_ffff, 32'h0);
    reg_write(PRIMARY_OFS, 32'h3);
    expect_reg(INT_STATUS_OFS, 32'hffff_ffff, 32'h1);
    expect_reg(PRIMARY_OFS, 32'h3, 32'h0);
    chk_irq(1'b1);
    reg_write(INT_STATUS_OFS, 32'h1);
    chk_irq(1'b0);
    expect_reg(12'h124, 32'hffff_ffff, 32'h0);
  endtask

  // Frozen clock enable drops a pulse; a mid-run reset restores defaults
  task automatic t_freeze_and_reset();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    pulse(0, 0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    expect_reg(PRIMARY_OFS, 32'h0020_0000, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset_values();
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    ref_clk         = 1'b0;
    resetn          = 1'b0;
    clk_en          = 1'b1;
    req             = '0;
    src             = '0;
    field_id_a_pin  = 1'b0;
    field_id_b_pin  = 1'b0;
    gp_pin          = 4'h0;
    fail_count      = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset_values();
    t_task0_timeout();
    t_busy_edges();
    t_xfer_errors();
    t_twowire_errors();
    t_audio_protect();
    t_faults();
    t_pins();
    t_counters();
    t_bus_and_task1();
    t_soft_trigger();
    t_freeze_and_reset();
    report_and_stop();
  end

  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #200us;
    fail_count++;
    report_and_stop();
  end
endmodule
